/* File: design/bpio_pin_sync.sv */
// two-stage synchroniser for one vector of pad levels
module bpio_pin_sync #(
    parameter int WIDTH = 8
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] rawIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stageOne;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stageOne <= '0;
            syncOut <= '0;
        end else begin
            stageOne <= rawIn;
            syncOut <= stageOne;
        end
    end
endmodule

/* File: design/bpio_pkg.sv */
// package: register map, field layout and reset values of the port block
package bpio_pkg;
    // apb byte addresses of each port's three locations, ports 16 bytes apart
    localparam int unsigned PORT_STRIDE = 16;
    localparam logic [7:0] OFS_OUTPUT_LATCH = 8'h00;
    localparam logic [7:0] OFS_DIRECTION = 8'h04;
    localparam logic [7:0] OFS_INPUT_PINS = 8'h08;
    // mcu control register, shared by all ports
    localparam logic [7:0] OFS_MCU_CONTROL = 8'hf0;
    localparam int unsigned MCU_PULLUP_DISABLE_BIT = 0;
    localparam logic [31:0] MCU_CONTROL_RESET = 32'h0000_0000;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [7:0] DIRECTION_RESET = 8'h00;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;
endpackage

/* File: design/bpio_port_ctrl.sv */
// bidirectional port pin control with apb registers and override interface
//
// What this block does
// - direction one enables driver, zero means input
// - input with latch one, no disable: pull-up
// - latch zero or output pin: pull-up off
// - output pin drives latch value onto pad
// - reset tri-states pins, pull-ups off, asynchronously
// - global pull-up disable kills every pull-up not under pull-up override
// - input bit reads pad, any direction
// - pad passes stageOne flip-flop then input register bit
// - sleep clamps digital input to ground
// - no clamp where interrupt enabled, or input enable override enabled with value one
// - clamp release gives an edge on pinLevel for downstream interrupt logic
// - pull-up override enable selects override value
// - direction override enable selects driver enable
// - value override drives override value when enabled
// - toggle override inverts the output latch bit
// - input enable override beats sleep state
// - alternate functions get unsynchronised input
// - analog link wired straight to pad
// - strobes per port, clock/sleep/disable shared
// - overrides come per pin from owning modules
// - writing one to input location toggles latch
// - three locations per port: latch, direction, input
//
// Design decisions made here: the APB interface to the registers and the register offsets.
module bpio_port_ctrl #(
    parameter int PORTS = 2,
    parameter int PINS = 8
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // shared sleep clamp from the sleep controller
    input wire logic sleepClamp,
    // external interrupt enable and edge sensing per pin
    input wire logic [PORTS*PINS-1:0] extIntEnable,
    // per-pin overrides from alternate-function owners
    input wire logic [PORTS*PINS-1:0] pullup_override_enable,
    input wire logic [PORTS*PINS-1:0] pullup_override_value,
    input wire logic [PORTS*PINS-1:0] direction_override_enable,
    input wire logic [PORTS*PINS-1:0] direction_override_value,
    input wire logic [PORTS*PINS-1:0] output_value_override_enable,
    input wire logic [PORTS*PINS-1:0] output_value_override_value,
    input wire logic [PORTS*PINS-1:0] output_toggle_override_enable,
    input wire logic [PORTS*PINS-1:0] input_enable_override_enable,
    input wire logic [PORTS*PINS-1:0] input_enable_override_value,
    // pad side, output enable low while driving
    input wire logic [PORTS*PINS-1:0] padIn,
    output logic [PORTS*PINS-1:0] padOut,
    output logic [PORTS*PINS-1:0] padOe_n,
    output logic [PORTS*PINS-1:0] padPullup,
    // to alternate functions
    output logic [PORTS*PINS-1:0] alt_function_raw_input,
    input wire logic [PORTS*PINS-1:0] analog_pad_link,
    output logic [PORTS*PINS-1:0] analogToAltFunction,
    // synchronised input levels, e.g. for interrupt edge detect
    output logic [PORTS*PINS-1:0] pinLevel
);
    localparam int N = PORTS * PINS;

    // ========================================================
    // register state
    // ========================================================
    logic [N-1:0] output_latch_register;
    logic [N-1:0] direction_register;
    logic [31:0] mcu_control_register;
    logic [N-1:0] input_pins_register;
    logic global_pullup_disable;

    // ========================================================
    // apb decode
    // ========================================================
    function automatic logic [7:0] portBase(input int p);
        portBase = 8'(p * bpio_pkg::PORT_STRIDE);
    endfunction

    wire apbSetup = psel && !penable;
    wire apbAccess = psel && penable;
    wire apbWrite = apbAccess && pwrite;
    wire hitMcu = paddr == bpio_pkg::OFS_MCU_CONTROL;

    // per-port strobes, shared by all pins of that port
    logic [PORTS-1:0] hitLatch;
    logic [PORTS-1:0] hitDir;
    logic [PORTS-1:0] hitPins;
    always_comb begin
        for (int p = 0; p < PORTS; p++) begin
            hitLatch[p] = paddr == portBase(p) + bpio_pkg::OFS_OUTPUT_LATCH;
            hitDir[p] = paddr == portBase(p) + bpio_pkg::OFS_DIRECTION;
            hitPins[p] = paddr == portBase(p) + bpio_pkg::OFS_INPUT_PINS;
        end
    end

    wire mapped = hitMcu || (|hitLatch) || (|hitDir) || (|hitPins);

    assign pready = 1'b1;
    assign global_pullup_disable =
        mcu_control_register[bpio_pkg::MCU_PULLUP_DISABLE_BIT];

    // ========================================================
    // latch and direction next values
    // ========================================================
    logic [N-1:0] next_output_latch_register;
    logic [N-1:0] next_direction_register;
    always_comb begin
        next_output_latch_register = output_latch_register;
        next_direction_register = direction_register;
        for (int p = 0; p < PORTS; p++) begin
            if (apbWrite && hitLatch[p]) begin
                next_output_latch_register[p*PINS +: PINS] =
                    pwdata[PINS-1:0];
            end
            if (apbWrite && hitPins[p]) begin
                next_output_latch_register[p*PINS +: PINS] =
                    output_latch_register[p*PINS +: PINS]
                    ^ pwdata[PINS-1:0];
            end
            if (apbWrite && hitDir[p]) begin
                next_direction_register[p*PINS +: PINS] = pwdata[PINS-1:0];
            end
        end
        // alternate-function toggle applies on top of any write
        next_output_latch_register = next_output_latch_register
            ^ output_toggle_override_enable;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            output_latch_register <=
                {PORTS{bpio_pkg::LATCH_RESET[PINS-1:0]}};
            direction_register <=
                {PORTS{bpio_pkg::DIRECTION_RESET[PINS-1:0]}};
            mcu_control_register <= bpio_pkg::MCU_CONTROL_RESET;
        end else begin
            output_latch_register <= next_output_latch_register;
            direction_register <= next_direction_register;
            if (apbWrite && hitMcu) begin
                mcu_control_register <= pwdata;
            end
        end
    end

    // ========================================================
    // pad control
    // ========================================================
    logic [N-1:0] driverOn;
    logic [N-1:0] normalPullup;
    logic [N-1:0] clampedLevel;
    logic [N-1:0] inputEnable;

    // per-pin choice between override value and normal control
    function automatic logic [N-1:0] overrideSel(
        input logic [N-1:0] en,
        input logic [N-1:0] val,
        input logic [N-1:0] norm
    );
        overrideSel = (en & val) | (~en & norm);
    endfunction

    assign driverOn = overrideSel(direction_override_enable,
        direction_override_value, direction_register);
    assign normalPullup = ~direction_register & output_latch_register
        & {N{~global_pullup_disable}};
    assign padPullup = overrideSel(pullup_override_enable,
        pullup_override_value, normalPullup);
    assign padOut = overrideSel(output_value_override_enable,
        output_value_override_value, output_latch_register);
    // registers reset asynchronously, so pads float at once
    assign padOe_n = ~driverOn;

    // sleep clamp unless interrupt enabled
    wire [N-1:0] normalInputEnable = ~{N{sleepClamp}} | extIntEnable;
    assign inputEnable = overrideSel(input_enable_override_enable,
        input_enable_override_value, normalInputEnable);
    // clamp forces ground; release gives edge downstream
    assign clampedLevel = padIn & inputEnable;

    // unsynchronised for alternate functions
    assign alt_function_raw_input = clampedLevel;
    assign analogToAltFunction = analog_pad_link;

    // ========================================================
    // input synchroniser
    // ========================================================
    bpio_pin_sync #(
        .WIDTH(N)
    ) u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .rawIn(clampedLevel),
        .syncOut(input_pins_register)
    );
    assign pinLevel = input_pins_register;

    // ========================================================
    // read data
    // ========================================================
    logic [31:0] readMux;
    always_comb begin
        readMux = bpio_pkg::READ_ZERO;
        if (hitMcu) begin
            readMux = mcu_control_register;
        end
        for (int p = 0; p < PORTS; p++) begin
            if (hitLatch[p]) begin
                readMux[PINS-1:0] = output_latch_register[p*PINS +: PINS];
            end
            if (hitDir[p]) begin
                readMux[PINS-1:0] = direction_register[p*PINS +: PINS];
            end
            if (hitPins[p]) begin
                // pad level regardless of direction
                readMux[PINS-1:0] = input_pins_register[p*PINS +: PINS];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= bpio_pkg::READ_ZERO;
        end else if (apbSetup && !pwrite) begin
            prdata <= readMux;
        end
    end

    assign pslverr = apbAccess && !mapped;
    // are kept by software; bits change freely here
endmodule

/* File: dv/bpio_pad_model.sv */
// pad model: external circuit behind the pins
module bpio_pad_model #(
    parameter int N = 16
) (
    input wire logic sys_clk,
    input wire logic [N-1:0] padOut,
    input wire logic [N-1:0] padOe_n,
    input wire logic [N-1:0] padPullup,
    input wire logic [N-1:0] extDrive,
    input wire logic [N-1:0] extEn,
    output logic [N-1:0] padIn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [N-1:0] floatLvl = '0;
    // undriven, unpulled pads wander every cycle
    always @(posedge sys_clk) floatLvl <= ~floatLvl;
    assign padIn = (~padOe_n & padOut) | (padOe_n & extEn & extDrive)
        | (padOe_n & ~extEn & (padPullup | floatLvl));
endmodule

/* File: dv/bpio_port_ctrl_asserts.sv */
// checker: port-level assertions for the pin control block
module bpio_port_ctrl_asserts #(
    parameter int N = 16
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pslverr,
    input wire logic sleepClamp,
    input wire logic [N-1:0] extIntEnable,
    input wire logic [N-1:0] pullup_override_enable,
    input wire logic [N-1:0] pullup_override_value,
    input wire logic [N-1:0] direction_override_enable,
    input wire logic [N-1:0] direction_override_value,
    input wire logic [N-1:0] output_value_override_enable,
    input wire logic [N-1:0] output_value_override_value,
    input wire logic [N-1:0] input_enable_override_enable,
    input wire logic [N-1:0] padIn,
    input wire logic [N-1:0] padOut,
    input wire logic [N-1:0] padOe_n,
    input wire logic [N-1:0] padPullup,
    input wire logic [N-1:0] pinLevel
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // ==========================================
    // pad and register relations
    a_reset_tristate: assert property (disable iff (1'b0)
        !rst_n |-> &padOe_n && padPullup == '0) else $error("pin not idle");
    a_output_no_pullup: assert property (
        (padPullup & ~padOe_n & ~pullup_override_enable
        & ~direction_override_enable) == '0) else $error("pull-up on output");
    a_pullup_override: assert property (
        (padPullup & pullup_override_enable) == (pullup_override_value
        & pullup_override_enable)) else $error("pull-up override ignored");
    a_driver_override: assert property (
        (~padOe_n & direction_override_enable) == (direction_override_value
        & direction_override_enable)) else $error("driver override ignored");
    a_value_override: assert property (
        (padOut & ~padOe_n & output_value_override_enable) ==
        (output_value_override_value & ~padOe_n & output_value_override_enable))
        else $error("value override ignored");
    a_sync_two_clocks: assert property (
        $past(rst_n, 2) && !$past(sleepClamp, 2)
        && $past(input_enable_override_enable, 2) == '0
        |-> pinLevel == $past(padIn, 2)) else $error("input latency wrong");
    a_clamp_ground: assert property (
        $past(sleepClamp, 2) && $past(extIntEnable
        | input_enable_override_enable, 2) == '0 |-> pinLevel == '0)
        else $error("clamped input not low");
    a_unmapped_err: assert property (
        psel && penable |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08,
        8'h10, 8'h14, 8'h18, 8'hf0})) else $error("error response wrong");
endmodule
bind bpio_port_ctrl bpio_port_ctrl_asserts #(.N(PORTS*PINS)) chk_i (.*);

/* File: dv/bpio_port_ctrl_test.sv */
// testbench: apb registers, pads, clamp and overrides of the pin block
module bpio_port_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic pready, pslverr, sleepClamp = 0;
    logic [7:0] paddr = '0, lat, dir, tg, base, lv [2];
    logic [31:0] pwdata = '0, prdata, expq [$];
    logic [15:0] extIntEnable = '0, pullup_override_enable = '0;
    logic [15:0] pullup_override_value = '0, direction_override_enable = '0;
    logic [15:0] direction_override_value = '0, input_enable_override_value = '0;
    logic [15:0] output_value_override_enable = '0, analog_pad_link = '0;
    logic [15:0] output_value_override_value = '0, extDrive = '0, extEn = '1;
    logic [15:0] output_toggle_override_enable = '0, padIn, padOut, padOe_n;
    logic [15:0] input_enable_override_enable = '0, padPullup, pinLevel;
    logic [15:0] alt_function_raw_input, analogToAltFunction;
    int fail_count = 0, checks = 0, cyc = 0;
    bpio_port_ctrl bpio_port_ctrl_i (.*);
    bpio_pad_model bpio_pad_model_i (.sys_clk(sys_clk), .padOut(padOut),
        .padOe_n(padOe_n), .padPullup(padPullup), .extDrive(extDrive),
        .extEn(extEn), .padIn(padIn));
    always #4 sys_clk = ~sys_clk;
    // ==========================================
    // shared tasks
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge sys_clk);
        penable <= 1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        {psel, penable} <= 2'b00;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expq.push_back(e);
        apb(0, a, 0);
    endtask
    task automatic lvl(input string nm, input logic [15:0] e);
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(nm, pinLevel, e);
    endtask
    task automatic end_sim;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail_count++;
            end_sim();
        end
        if (psel && penable && pready && !pwrite)
            chk("prdata", prdata, expq.pop_front());
    end
    // ==========================================
    // main sequence
    initial begin
        void'($urandom(89200));
        repeat (8) @(posedge sys_clk);
        chk("reset oe", padOe_n, 16'hffff);
        rst_n <= 1;
        extDrive <= 16'($urandom);
        analog_pad_link <= 16'($urandom);
        for (int p = 0; p < 2; p++) begin
            {lat, dir, tg} = 24'($urandom);
            base = 8'(p * 16);
            rd(base, 0);
            rd(base + 4, 0);
            apb(1, base, {$urandom, lat}); // latch first
            apb(1, base + 4, dir);
            rd(base + 4, dir);
            rd(base + 8, 8'((dir & lat) | (~dir & extDrive[p*8+:8])));
            chk("oe", padOe_n[p*8+:8], 8'(~dir));
            chk("pullup", padPullup[p*8+:8], 8'(~dir & lat));
            chk("out", padOut[p*8+:8] & dir, lat & dir);
            apb(1, base + 8, tg);
            lv[p] = lat ^ tg;
            rd(base, lv[p]);
        end
        $display("test registers done");
        apb(1, 8'hf0, 1);
        rd(8'hf0, 1);
        chk("pud", padPullup, 0);
        apb(1, 8'hf0, 0);
        rd(8'h0c, 0);
        @(posedge sys_clk) output_toggle_override_enable <= 16'h0001;
        @(posedge sys_clk) output_toggle_override_enable <= '0;
        rd(8'h00, lv[0] ^ 8'h01);
        repeat (20) @(posedge sys_clk) {pullup_override_enable,
            pullup_override_value, direction_override_enable,
            direction_override_value, output_value_override_enable,
            output_value_override_value} <= {$urandom, $urandom, $urandom};
        @(posedge sys_clk) {pullup_override_enable, direction_override_enable,
            output_value_override_enable} <= '0;
        $display("test overrides done");
        apb(1, 8'h04, 0);
        apb(1, 8'h14, 0);
        extEn <= '0;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("pull in", pinLevel & padPullup, padPullup);
        chk("pull map", padPullup, {lv[1], lv[0] ^ 8'h01});
        @(posedge sys_clk) extEn <= '1;
        sleepClamp <= 1;
        lvl("clamp", 0);
        extIntEnable <= '1;
        lvl("int keeps", extDrive);
        {extIntEnable, input_enable_override_enable} <= {16'h0000, 16'hffff};
        input_enable_override_value <= '1;
        lvl("ie on", extDrive);
        chk("raw", alt_function_raw_input, extDrive);
        chk("analog", analogToAltFunction, analog_pad_link);
        {sleepClamp, input_enable_override_value} <= '0;
        lvl("ie off", 0);
        $display("test clamp done");
        @(posedge sys_clk) rst_n <= 0;
        #1 chk("async oe", padOe_n, 16'hffff);
        repeat (2) @(posedge sys_clk);
        rst_n <= 1;
        $display("test reset done");
        end_sim();
    end
endmodule
